// *** pttsc_pkg.sv ***
// Shared constants, register map and helpers of the pulse timer control
package pttsc_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int VAL_W  = 10;
    localparam int CNT_W  = 11;

    localparam logic [ADDR_W-1:0] ADR_CTRL1  = 4'h0;
    localparam logic [ADDR_W-1:0] ADR_CTRL2  = 4'h1;
    localparam logic [ADDR_W-1:0] ADR_CTRL3  = 4'h2;
    localparam logic [ADDR_W-1:0] ADR_PERIOD = 4'h3;
    localparam logic [ADDR_W-1:0] ADR_DEAD_A = 4'h4;
    localparam logic [ADDR_W-1:0] ADR_WID_A  = 4'h5;
    localparam logic [ADDR_W-1:0] ADR_DEAD_B = 4'h6;
    localparam logic [ADDR_W-1:0] ADR_WID_B  = 4'h7;

    // Control register one fields
    localparam int C1_ACCEPT_MODE = 0;
    localparam int C1_EDGE_SEL    = 1;
    localparam int C1_INIT_A      = 2;
    localparam int C1_INIT_B      = 3;
    localparam int C1_NF_LO       = 4;
    // Control register two fields
    localparam int C2_OE_A = 0;
    localparam int C2_OE_B = 1;
    // Control register three fields
    localparam int C3_RUN    = 0;
    localparam int C3_STM_LO = 1;
    localparam int C3_BUSY   = 3;

    localparam logic [1:0] STM_INIT = 2'h0;
    localparam logic [1:0] STM_HOLD = 2'h1;
    localparam logic [1:0] STM_END  = 2'h2;

    localparam logic [1:0] NF_DIV4   = 2'h0;
    localparam logic [1:0] NF_DIV2   = 2'h1;
    localparam logic [1:0] NF_FULL   = 2'h2;
    localparam logic [1:0] NF_BYPASS = 2'h3;
    localparam int         NF_TAPS   = 5;

    localparam logic [VAL_W-1:0] VAL_RST = 10'h000;

    // A stored zero stands for the full range of 400h
    function automatic logic [CNT_W-1:0] ext_val(input logic [VAL_W-1:0] v);
        ext_val = {(v == VAL_RST), v};
    endfunction

endpackage

// *** pttsc_noise_filter.sv ***
// Trigger pin synchroniser and five-sample digital noise canceller
`timescale 1ns/10ps
module pttsc_noise_filter (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_i,
    input  wire logic       pin_i,
    input  wire logic [1:0] nf_sel_i,
    output logic            level_o
);
    logic                         s1_r, s2_r, s3_r;
    logic                         sync_r;
    logic [1:0]                   div_r;
    logic [pttsc_pkg::NF_TAPS-1:0] taps_r;
    logic                         smp_en;
    logic                         all_hi;
    logic                         all_lo;

    // Sample rate from the filter select: fc/4, fc/2 or fc
    assign smp_en = (nf_sel_i == pttsc_pkg::NF_DIV4) ? (div_r == 2'h3) :
                    (nf_sel_i == pttsc_pkg::NF_DIV2) ? div_r[0] : 1'b1;
    assign all_hi = &taps_r;
    assign all_lo = ~|taps_r;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sync_r <= 1'b0;
            div_r  <= 2'h0;
            taps_r <= '0;
        end else begin
            div_r <= div_r + 2'h1;
            if (s2_r == s3_r) begin
                sync_r <= s3_r;
            end
            if (smp_en) begin
                taps_r <= {taps_r[pttsc_pkg::NF_TAPS-2:0], sync_r};
            end
        end
    end

    // Outside bypass, level passes only after five agreeing samples; shorter ones die
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            level_o <= 1'b0;
        end else if (nf_sel_i == pttsc_pkg::NF_BYPASS) begin
            level_o <= sync_r;
        end else if (all_hi) begin
            level_o <= 1'b1;
        end else if (all_lo) begin
            level_o <= 1'b0;
        end
    end
endmodule

// *** pttsc_pulse_chan.sv ***
// One pulse output channel: dead time and width compare with polarity
`timescale 1ns/10ps
module pttsc_pulse_chan (
    input  wire logic                        clk_sys_i,
    input  wire logic                        rst_i,
    input  wire logic [pttsc_pkg::CNT_W-1:0] cnt_i,
    input  wire logic [pttsc_pkg::VAL_W-1:0] dead_i,
    input  wire logic [pttsc_pkg::VAL_W-1:0] width_i,
    input  wire logic                        init_lvl_i,
    input  wire logic                        out_en_i,
    input  wire logic                        load_init_i,
    input  wire logic                        run_i,
    output logic                             pulse_o,
    output logic                             pulse_oe_o,
    output logic                             active_o
);
    logic phase;

    assign phase = (cnt_i >= {1'b0, dead_i}) && (cnt_i < pttsc_pkg::ext_val(width_i));

    // Disabled channel keeps its idle level and releases the pin
    assign pulse_oe_o = out_en_i;
    // Only an enabled channel counts as active for trigger gating
    assign active_o   = out_en_i && (pulse_o != init_lvl_i);

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            pulse_o <= 1'b0;
        end else if (load_init_i) begin
            pulse_o <= init_lvl_i;
        end else if (run_i) begin
            pulse_o <= init_lvl_i ^ (phase & out_en_i);
        end
    end
endmodule

// *** pttsc_ctrl.sv ***
// Pulse timer trigger, stop and output control with its register file
//
// Functional notes
// - Accept mode 0 takes every trigger, outputs inactive
// - Accept mode 1 takes triggers only when inactive
// - Only enabled outputs count toward acceptance
// - Stop while active waits until outputs inactive
// - Both enabled: both must be inactive together
// - Stop mode 00 stops now, outputs initial
// - Stop mode 01 holds outputs; restart reloads initial
// - Stop mode 10 stops at period end
// - Busy flag readable in control register three
// - One-time trigger start waits for next trigger
// - One-time command start waits; run stays 1
// - Writing mode 10 while running restarts count
// - Stop modes 00/01 give continuous output
// - Initial-level bit sets output polarity
// - Disabled output carries no waveform
// - Both disabled: plain timer with period pulse
// - Filter needs five stable samples
// - Filter select picks fc/4, fc/2, fc, bypass
// - Rejection and acceptance widths scale with rate
// - Filter latency follows the sample rate
// - Edge select sets start edge and stop level
// - Triggers ignored while run control is 0; a stop trigger is still taken during a pending period-end stop
//
// Added by the designer: strobed register access and the address map.
`timescale 1ns/10ps
module pttsc_ctrl (
    input  wire logic                         clk_sys_i,
    input  wire logic                         rst_i,
    input  wire logic [pttsc_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [pttsc_pkg::DATA_W-1:0] wdata_i,
    input  wire logic                         wr_i,
    input  wire logic                         rd_i,
    output logic      [pttsc_pkg::DATA_W-1:0] rdata_o,
    input  wire logic                         trigger_input_pin_i,
    output logic                              pulse_out_a_o,
    output logic                              pulse_out_a_oe_o,
    output logic                              pulse_out_b_o,
    output logic                              pulse_out_b_oe_o,
    output logic                              period_interrupt_o,
    output logic                              count_busy_flag_o
);
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_WAIT
    } pttsc_state_t;

    pttsc_state_t                  state_r;
    pttsc_state_t                  state_nxt;

    // Software registers
    logic                          accept_mode_r;
    logic                          edge_sel_r;
    logic [1:0]                    init_lvl_r;
    logic [1:0]                    nf_sel_r;
    logic [1:0]                    out_en_r;
    logic                          run_r;
    logic [1:0]                    stm_r;
    logic [pttsc_pkg::VAL_W-1:0]   period_r;
    logic [pttsc_pkg::VAL_W-1:0]   dead_r   [2];
    logic [pttsc_pkg::VAL_W-1:0]   width_r  [2];
    logic [pttsc_pkg::DATA_W-1:0]  rdata_nxt;

    // Timer state
    logic [pttsc_pkg::CNT_W-1:0]   cnt_r;
    logic [pttsc_pkg::CNT_W-1:0]   cnt_nxt;
    logic                          pend_stop_r;
    logic                          pend_stop_nxt;
    logic                          trig_prev_r;
    logic                          irq_r;
    logic                          irq_nxt;
    logic                          load_init;

    // Decode and trigger wires
    logic                          wr_c1;
    logic                          wr_c2;
    logic                          wr_c3;
    logic [1:0]                    wr_stm;
    logic                          run_set;
    logic                          run_clr;
    logic                          trig_lvl;
    logic                          stop_lvl;
    logic                          at_stop;
    logic                          start_edge;
    logic                          outs_active;
    logic                          accept_ok;
    logic                          trig_en;
    logic                          stop_trig;
    logic                          start_trig;
    logic                          period_end;
    logic [pttsc_pkg::CNT_W-1:0]   period_last;
    logic [1:0]                    chan_active;
    logic [1:0]                    chan_pulse;
    logic [1:0]                    chan_oe;
    logic                          chan_run;

    function automatic logic hit(input logic [pttsc_pkg::ADDR_W-1:0] a);
        hit = wr_i && (addr_i == a);
    endfunction

    assign wr_c1   = hit(pttsc_pkg::ADR_CTRL1);
    assign wr_c2   = hit(pttsc_pkg::ADR_CTRL2);
    assign wr_c3   = hit(pttsc_pkg::ADR_CTRL3);
    assign wr_stm  = wdata_i[pttsc_pkg::C3_STM_LO +: 2];
    // Writing run 1 always clears the count; it restarts unless the pin sits at stop level, also in one-time mode
    assign run_set = wr_c3 && wdata_i[pttsc_pkg::C3_RUN];
    assign run_clr = wr_c3 && !wdata_i[pttsc_pkg::C3_RUN] && run_r;

    // Trigger polarity: edge select 0 means falling starts, high stops
    assign stop_lvl   = ~edge_sel_r;
    assign at_stop    = (trig_lvl == stop_lvl);
    assign start_edge = (trig_prev_r == stop_lvl) && !at_stop;

    // Acceptance gate from the enabled outputs' activity
    assign outs_active = |chan_active;
    assign accept_ok   = !accept_mode_r || !outs_active;

    // A pending end-of-period stop still honours a stop trigger
    assign trig_en = run_r || pend_stop_r;
    // Stop level is a level, so a refused one is taken as soon as
    // the outputs fall inactive while the pin still sits there
    assign stop_trig  = trig_en && at_stop && accept_ok && (state_r == ST_RUN);
    // A start edge refused while active is lost, not deferred
    assign start_trig = run_r && start_edge && accept_ok && (state_r != ST_IDLE);

    assign period_last = pttsc_pkg::ext_val(period_r) - 11'h001;
    assign period_end  = (state_r == ST_RUN) && (cnt_r == period_last);
    assign chan_run    = (state_r == ST_RUN) && !load_init;

    pttsc_noise_filter u_filter (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .pin_i     (trigger_input_pin_i),
        .nf_sel_i  (nf_sel_r),
        .level_o   (trig_lvl)
    );

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_chan
            pttsc_pulse_chan u_chan (
                .clk_sys_i   (clk_sys_i),
                .rst_i       (rst_i),
                .cnt_i       (cnt_r),
                .dead_i      (dead_r[gi]),
                .width_i     (width_r[gi]),
                .init_lvl_i  (init_lvl_r[gi]),
                .out_en_i    (out_en_r[gi]),
                .load_init_i (load_init),
                .run_i       (chan_run),
                .pulse_o     (chan_pulse[gi]),
                .pulse_oe_o  (chan_oe[gi]),
                .active_o    (chan_active[gi])
            );
        end
    endgenerate

    assign pulse_out_a_o    = chan_pulse[0];
    assign pulse_out_b_o    = chan_pulse[1];
    assign pulse_out_a_oe_o = chan_oe[0];
    assign pulse_out_b_oe_o = chan_oe[1];
    // Busy while the counter still runs, including a pending stop
    assign count_busy_flag_o = (state_r == ST_RUN);

    // Counter sequencing
    always_comb begin
        state_nxt     = state_r;
        cnt_nxt       = cnt_r;
        pend_stop_nxt = pend_stop_r;
        load_init     = 1'b0;
        irq_nxt       = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (run_set) begin
                    // Pin at stop level blocks a command start
                    state_nxt = at_stop ? ST_WAIT : ST_RUN;
                    irq_nxt   = !at_stop;
                    cnt_nxt   = '0;
                    load_init = 1'b1;
                end
            end
            ST_RUN: begin
                if (run_set) begin
                    state_nxt     = at_stop ? ST_WAIT : ST_RUN;
                    irq_nxt       = !at_stop;
                    cnt_nxt       = '0;
                    pend_stop_nxt = 1'b0;
                    load_init     = 1'b1;
                end else if (run_clr && (wr_stm == pttsc_pkg::STM_INIT)) begin
                    state_nxt = ST_IDLE;
                    cnt_nxt   = '0;
                    load_init = 1'b1;
                end else if (run_clr && (wr_stm == pttsc_pkg::STM_HOLD)) begin
                    // Outputs freeze because the channels stop updating
                    state_nxt = ST_IDLE;
                    cnt_nxt   = '0;
                end else if (run_clr) begin
                    pend_stop_nxt = 1'b1;
                    cnt_nxt       = cnt_r + 11'h001;
                end else if (stop_trig) begin
                    // Pin stop clears the count and idles the outputs
                    state_nxt     = pend_stop_r ? ST_IDLE : ST_WAIT;
                    pend_stop_nxt = 1'b0;
                    cnt_nxt       = '0;
                    load_init     = 1'b1;
                end else if (start_trig) begin
                    cnt_nxt   = '0;
                    load_init = 1'b1;
                end else if (period_end) begin
                    cnt_nxt = '0;
                    irq_nxt = 1'b1;
                    if (pend_stop_r) begin
                        state_nxt     = ST_IDLE;
                        pend_stop_nxt = 1'b0;
                        load_init     = 1'b1;
                    end else if (stm_r == pttsc_pkg::STM_END) begin
                        // One-time: stop but keep run control set
                        state_nxt = ST_WAIT;
                        load_init = 1'b1;
                    end
                    // Otherwise the waveform simply repeats
                end else begin
                    cnt_nxt = cnt_r + 11'h001;
                end
            end
            ST_WAIT: begin
                if (run_set) begin
                    state_nxt = at_stop ? ST_WAIT : ST_RUN;
                    irq_nxt   = !at_stop;
                    cnt_nxt   = '0;
                    load_init = 1'b1;
                end else if (run_clr) begin
                    state_nxt = ST_IDLE;
                end else if (start_trig) begin
                    state_nxt = ST_RUN;
                    cnt_nxt   = '0;
                    load_init = 1'b1;
                end
            end
            default: begin
                state_nxt     = ST_IDLE;
                cnt_nxt       = '0;
                pend_stop_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_r     <= ST_IDLE;
            cnt_r       <= '0;
            pend_stop_r <= 1'b0;
            irq_r       <= 1'b0;
            trig_prev_r <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            cnt_r       <= cnt_nxt;
            pend_stop_r <= pend_stop_nxt;
            irq_r       <= irq_nxt;
            trig_prev_r <= trig_lvl;
        end
    end

    assign period_interrupt_o = irq_r;

    // Control register writes; no guard against rewriting while busy,
    // software is expected to check the busy flag first
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            accept_mode_r <= 1'b0;
            edge_sel_r    <= 1'b0;
            init_lvl_r    <= 2'h0;
            nf_sel_r      <= pttsc_pkg::NF_DIV4;
            out_en_r      <= 2'h0;
        end else if (wr_c1) begin
            accept_mode_r <= wdata_i[pttsc_pkg::C1_ACCEPT_MODE];
            edge_sel_r    <= wdata_i[pttsc_pkg::C1_EDGE_SEL];
            init_lvl_r    <= {wdata_i[pttsc_pkg::C1_INIT_B], wdata_i[pttsc_pkg::C1_INIT_A]};
            nf_sel_r      <= wdata_i[pttsc_pkg::C1_NF_LO +: 2];
        end else if (wr_c2) begin
            out_en_r <= {wdata_i[pttsc_pkg::C2_OE_B], wdata_i[pttsc_pkg::C2_OE_A]};
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            run_r <= 1'b0;
            stm_r <= pttsc_pkg::STM_INIT;
        end else if (wr_c3) begin
            run_r <= wdata_i[pttsc_pkg::C3_RUN];
            stm_r <= wr_stm;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            period_r   <= pttsc_pkg::VAL_RST;
            dead_r[0]  <= pttsc_pkg::VAL_RST;
            dead_r[1]  <= pttsc_pkg::VAL_RST;
            width_r[0] <= pttsc_pkg::VAL_RST;
            width_r[1] <= pttsc_pkg::VAL_RST;
        end else if (wr_i) begin
            case (addr_i)
                pttsc_pkg::ADR_PERIOD: period_r   <= wdata_i[pttsc_pkg::VAL_W-1:0];
                pttsc_pkg::ADR_DEAD_A: dead_r[0]  <= wdata_i[pttsc_pkg::VAL_W-1:0];
                pttsc_pkg::ADR_WID_A:  width_r[0] <= wdata_i[pttsc_pkg::VAL_W-1:0];
                pttsc_pkg::ADR_DEAD_B: dead_r[1]  <= wdata_i[pttsc_pkg::VAL_W-1:0];
                pttsc_pkg::ADR_WID_B:  width_r[1] <= wdata_i[pttsc_pkg::VAL_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // Read mux; unmapped addresses and reserved bits read as zero
    always_comb begin
        rdata_nxt = '0;
        case (addr_i)
            pttsc_pkg::ADR_CTRL1: begin
                rdata_nxt[pttsc_pkg::C1_ACCEPT_MODE] = accept_mode_r;
                rdata_nxt[pttsc_pkg::C1_EDGE_SEL]    = edge_sel_r;
                rdata_nxt[pttsc_pkg::C1_INIT_A]      = init_lvl_r[0];
                rdata_nxt[pttsc_pkg::C1_INIT_B]      = init_lvl_r[1];
                rdata_nxt[pttsc_pkg::C1_NF_LO +: 2]  = nf_sel_r;
            end
            pttsc_pkg::ADR_CTRL2: begin
                rdata_nxt[pttsc_pkg::C2_OE_A] = out_en_r[0];
                rdata_nxt[pttsc_pkg::C2_OE_B] = out_en_r[1];
            end
            pttsc_pkg::ADR_CTRL3: begin
                rdata_nxt[pttsc_pkg::C3_RUN]       = run_r;
                rdata_nxt[pttsc_pkg::C3_STM_LO +: 2] = stm_r;
                rdata_nxt[pttsc_pkg::C3_BUSY]      = count_busy_flag_o;
            end
            pttsc_pkg::ADR_PERIOD: rdata_nxt[pttsc_pkg::VAL_W-1:0] = period_r;
            pttsc_pkg::ADR_DEAD_A: rdata_nxt[pttsc_pkg::VAL_W-1:0] = dead_r[0];
            pttsc_pkg::ADR_WID_A:  rdata_nxt[pttsc_pkg::VAL_W-1:0] = width_r[0];
            pttsc_pkg::ADR_DEAD_B: rdata_nxt[pttsc_pkg::VAL_W-1:0] = dead_r[1];
            pttsc_pkg::ADR_WID_B:  rdata_nxt[pttsc_pkg::VAL_W-1:0] = width_r[1];
            default: rdata_nxt = '0;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= rd_i ? rdata_nxt : '0;
        end
    end
endmodule

// *** pttsc_monitor.sv ***
// Port checker of the pulse timer control
`timescale 1ns/10ps
module pttsc_monitor (
    input wire logic                         clk_sys_i,
    input wire logic                         rst_i,
    input wire logic [pttsc_pkg::ADDR_W-1:0] addr_i,
    input wire logic [pttsc_pkg::DATA_W-1:0] wdata_i,
    input wire logic                         wr_i,
    input wire logic                         rd_i,
    input wire logic [pttsc_pkg::DATA_W-1:0] rdata_o,
    input wire logic                         pulse_out_a_o,
    input wire logic                         pulse_out_a_oe_o,
    input wire logic                         pulse_out_b_o,
    input wire logic                         pulse_out_b_oe_o,
    input wire logic                         period_interrupt_o,
    input wire logic                         count_busy_flag_o
);
    logic init_a_r;
    logic init_b_r;
    logic run_r;
    wire  wr_c1 = wr_i && addr_i == pttsc_pkg::ADR_CTRL1;
    wire  wr_c2 = wr_i && addr_i == pttsc_pkg::ADR_CTRL2;
    wire  wr_c3 = wr_i && addr_i == pttsc_pkg::ADR_CTRL3;
    // Shadow of written control bits
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            init_a_r <= 1'b0;
            init_b_r <= 1'b0;
            run_r    <= 1'b0;
        end else begin
            if (wr_c1) {init_b_r, init_a_r} <= wdata_i[3:2];
            if (wr_c3) run_r <= wdata_i[0];
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    sequence s_cmd(m);
        wr_c3 && wdata_i[2:0] == m;
    endsequence
    property p_rd_idle; !$past(rd_i) |-> rdata_o == 16'h0000; endproperty
    property p_oe; wr_c2 |=> {pulse_out_b_oe_o, pulse_out_a_oe_o} == $past(wdata_i[1:0]);
    endproperty
    property p_start; wr_c3 && wdata_i[0] |=> period_interrupt_o == count_busy_flag_o;
    endproperty
    property p_stop_init; s_cmd(3'b000) |-> ##2 (!count_busy_flag_o &&
        pulse_out_a_o == init_a_r && pulse_out_b_o == init_b_r); endproperty
    property p_stop_hold; s_cmd(3'b010) |-> ##2 ($stable(pulse_out_a_o) &&
        $stable(pulse_out_b_o) && !count_busy_flag_o) [*6]; endproperty
    property p_idle; !run_r && !count_busy_flag_o && !wr_i |=> !count_busy_flag_o;
    endproperty
    property p_irq_one; period_interrupt_o && !wr_i |=> !period_interrupt_o; endproperty
    property p_busy_rd; rd_i && addr_i == pttsc_pkg::ADR_CTRL3 |=>
        rdata_o[3] == $past(count_busy_flag_o); endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
    a_oe: assert property (p_oe) else $error("enable differs");
    a_start: assert property (p_start) else $error("start pulse vs busy");
    a_stop_init: assert property (p_stop_init) else $error("stop left outputs off");
    a_stop_hold: assert property (p_stop_hold) else $error("held outputs moved");
    a_idle: assert property (p_idle) else $error("busy with run off");
    a_irq_one: assert property (p_irq_one) else $error("period pulse too long");
    a_busy_rd: assert property (p_busy_rd) else $error("busy bit read wrong");
endmodule
bind pttsc_ctrl pttsc_monitor i_pttsc_monitor (.clk_sys_i, .rst_i, .addr_i, .wdata_i, .wr_i,
    .rd_i, .rdata_o, .pulse_out_a_o, .pulse_out_a_oe_o, .pulse_out_b_o, .pulse_out_b_oe_o,
    .period_interrupt_o, .count_busy_flag_o);

// *** pttsc_trig_src.sv ***
// Trigger pin source playing pulses of set length
`timescale 1ns/10ps
module pttsc_trig_src (
    input  wire logic       clk_sys_i,
    input  wire logic       idle_lvl_i,
    input  wire logic       go_i,
    input  wire logic [7:0] len_i,
    output logic            pin_o
);
    logic [7:0] left_r = 8'h00;
    always_ff @(posedge clk_sys_i) begin
        if (go_i) left_r <= len_i;
        else if (left_r != 8'h00) left_r <= left_r - 8'h01;
    end
    // Short pulses model noise
    assign pin_o = (left_r != 8'h00) ? !idle_lvl_i : idle_lvl_i;
endmodule

// *** pulse_timer_trigger_stop_ctrl_bench.sv ***
// Bench of the pulse timer control
`timescale 1ns/10ps
module pulse_timer_trigger_stop_ctrl_bench;
    logic clk_sys_i = 1'b0, rst_i = 1'b1, wr = 1'b0, rd = 1'b0, go = 1'b0, idle = 1'b0;
    logic pin, pa, pa_oe, pb, pb_oe, irq, busy;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000, rdata;
    logic [7:0] len = 8'h00;
    int n_fail = 0, checks = 0, per, dd, ww, seen;
    localparam logic [3:0] C1 = pttsc_pkg::ADR_CTRL1, C2 = pttsc_pkg::ADR_CTRL2;
    localparam logic [3:0] C3 = pttsc_pkg::ADR_CTRL3;
    initial forever #25 clk_sys_i = !clk_sys_i;
    pttsc_trig_src i_pttsc_trig_src (.clk_sys_i, .idle_lvl_i(idle), .go_i(go),
        .len_i(len), .pin_o(pin));
    pttsc_ctrl i_pttsc_ctrl (.clk_sys_i, .rst_i, .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .trigger_input_pin_i(pin),
        .pulse_out_a_o(pa), .pulse_out_a_oe_o(pa_oe), .pulse_out_b_o(pb),
        .pulse_out_b_oe_o(pb_oe), .period_interrupt_o(irq), .count_busy_flag_o(busy));
    task conclude;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask
    task wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys_i);
        wr <= 1'b0;
    endtask
    task rd_reg(input logic [3:0] a, output logic [15:0] v);
        @(posedge clk_sys_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys_i);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task pulse(input logic [7:0] l);
        @(posedge clk_sys_i);
        len <= l;
        go <= 1'b1;
        @(posedge clk_sys_i);
        go <= 1'b0;
    endtask
    // Settled cycles until the level shows, bounded
    task automatic wait_lvl(ref logic s, input logic l, input int lim);
        seen = 0;
        #1;
        while (s !== l && seen < lim) begin
            @(posedge clk_sys_i);
            #1 seen++;
        end
    endtask
    function logic [1:0] exp_out(input logic [1:0] ini, input logic [1:0] oe, input int k);
        return ini ^ (oe & {2{k >= dd && k < ww}});
    endfunction
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        n_fail++;
        conclude();
    end
    initial begin
        logic [15:0] v;
        logic [1:0] oe, ini;
        void'($urandom(11166));
        per = 4 + $urandom % 6;
        dd = $urandom % 3;
        ww = dd + 1 + $urandom % (per - dd - 1);
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        rd_reg(C3, v);
        chk(v, 16'h0000);
        wr_reg(pttsc_pkg::ADR_PERIOD, 16'(per));
        for (int a = 4; a < 8; a++) wr_reg(4'(a), 16'(a[0] ? ww : dd));
        rd_reg(pttsc_pkg::ADR_WID_B, v);
        chk(v, 16'(ww));
        rd_reg(4'hf, v);
        chk(v, 16'h0000);
        for (int i = 0; i < 3; i++) begin
            oe = 2'(3 >> i);
            ini = 2'($urandom);
            wr_reg(C1, {12'h000, ini, 2'b00});
            wr_reg(C2, {14'h0000, oe});
            wr_reg(C3, 16'h0001);
            wait_lvl(irq, 1'b1, 10);
            for (int k = 0; k < 2 * per; k++) begin
                @(posedge clk_sys_i);
                #1 chk({pb, pa}, exp_out(ini, oe, k % per));
                chk(irq, k % per == per - 1);
            end
            wr_reg(C3, {13'h0000, 2'(i), 1'b0});
            wait_lvl(busy, 1'b0, per + 2);
            if (i == 2) chk(seen > 0 && seen <= per, 1'b1);
            repeat (10) @(posedge clk_sys_i);
        end
        wr_reg(C3, 16'h0005);
        wait_lvl(busy, 1'b0, per + 3);
        chk(seen >= per - 1 && seen <= per + 1, 1'b1);
        repeat (2 * per) @(posedge clk_sys_i);
        #1 chk(busy, 1'b0);
        rd_reg(C3, v);
        chk(v, 16'h0005);
        wr_reg(C3, 16'h0005);
        #1 chk(busy, 1'b1);
        // Run control cleared only when idle
        wait_lvl(busy, 1'b0, per + 3);
        wr_reg(C3, 16'h0000);
        for (int n = 0; n < 4; n++) begin
            idle <= n[0];
            wr_reg(C1, {10'h000, 2'(n), 2'b00, n[0], 1'b0});
            wr_reg(C2, 16'h0003);
            repeat (40) @(posedge clk_sys_i);
            wr_reg(C3, 16'h0001);
            if (n < 3) begin
                pulse(8'(16 >> n));
                wait_lvl(busy, 1'b0, 40);
                chk(seen, 40);
            end
            pulse(n == 3 ? 8'h02 : 8'(20 >> n));
            wait_lvl(busy, 1'b0, 40);
            chk(seen < 30, 1'b1);
            wait_lvl(busy, 1'b1, 40);
            chk(seen < 30, 1'b1);
        end
        // Outputs held active, so a stop level waits
        wr_reg(C1, 16'h0033);
        for (int a = 4; a < 8; a++) wr_reg(4'(a), 16'(a[0] ? per : 0));
        wr_reg(C3, 16'h0001);
        pulse(8'd200);
        wait_lvl(busy, 1'b0, 40);
        chk(seen, 40);
        wr_reg(C2, 16'h0000);
        wait_lvl(busy, 1'b0, 10);
        chk(seen < 10, 1'b1);
        conclude();
    end
endmodule
